// File: rtl/bsp_link_if.sv
// Link between the SRAM controller end and the SRAM device end.
// Assumes both ends run on the same clock; each end drives its own data wires with its own enable.
`timescale 1ns/100ps
interface bsp_link_if;
	import bsp_pkg::*;
	logic                 k_phase;
	logic [ADDR_W-1:0]    sync_address_inputs;
	logic                 load_strobe_n;
	logic                 rw_select;
	logic [LANES-1:0]     byte_write_masks_n;
	logic [DQ_W-1:0]      ctl_dq;
	logic                 ctl_dq_oe_n;
	logic [DQ_W-1:0]      dev_dq;
	logic                 dev_dq_oe_n;
	logic                 termination_enable;
	logic                 dll_off_n;
	logic                 echo_timing_out;
	logic                 read_valid_out;
	modport ctl (output k_phase, sync_address_inputs, load_strobe_n, rw_select,
		byte_write_masks_n, ctl_dq, ctl_dq_oe_n, termination_enable, dll_off_n,
		input dev_dq, dev_dq_oe_n, echo_timing_out, read_valid_out);
	modport dev (input k_phase, sync_address_inputs, load_strobe_n, rw_select,
		byte_write_masks_n, ctl_dq, ctl_dq_oe_n, termination_enable, dll_off_n,
		output dev_dq, dev_dq_oe_n, echo_timing_out, read_valid_out);
endinterface : bsp_link_if

// File: rtl/bsp_pkg.sv
// Constants shared by both ends of the two-beat common-I/O SRAM port.
// Assumes one clock in which each cycle is one data beat.
// Function
// - Command pins sampled only at primary edges.
// - Read is load low, select high.
// - Each command moves exactly two beats.
// - Back-to-back commands accepted every primary cycle.
// - Deselect pipelined; read beats finish first.
// - Load high ignores command inputs.
// - Write beats captured primary then complementary.
// - Controller writes with both low, data later.
// - Masks sampled with each data beat.
// - Masked byte leaves stored contents unchanged.
// - Any mask mix, each lane independent.
// - Nine-bit variant: one mask, nine lines.
// - Eight-bit variant: nibble masks per four lines.
// - Internal word twice the bus width.
// - Low disable input turns off delay loop.
// - Termination follows termination enable pin level.
// - Drivers off one cycle after NOP/write.
// - Termination off half cycle around read data.
// - Controller drives writes, releases during reads.
package bsp_pkg;
	localparam int DQ_W       = 18;
	localparam int LANE_W     = 9;
	localparam int LANES      = DQ_W / LANE_W;
	localparam int WORD_W     = 2 * DQ_W;
	localparam int WMASK_W    = 2 * LANES;
	localparam int ADDR_W     = 4;
	localparam int DEPTH      = 16;
	// Beat counts after the device's command edge.
	localparam int WR_BEAT1   = 2;
	localparam int WR_BEAT2   = 3;
	localparam int RD_LAT     = 4;
	localparam int DRV_OFF    = 5;
	localparam int TERM_LEAD  = 1;
	localparam int DEV_PIPE   = 6;
	localparam int CTL_PIPE   = 7;
	localparam logic [1:0] CMD_NOP = 2'h0;
	localparam logic [1:0] CMD_WR  = 2'h1;
	localparam logic [1:0] CMD_RD  = 2'h2;
	typedef logic [1:0] bsp_cmd_t;
endpackage : bsp_pkg

// File: rtl/bsp_sram_ctl.sv
// SRAM controller end: issues at most one command per primary cycle, none in the two after a read, and moves the data beats.
// Assumes the device end shares clk_sys_in.
`timescale 1ns/100ps
module bsp_sram_ctl (
	input  wire logic                  clk_sys_in,
	input  wire logic                  arst_n_in,
	bsp_link_if.ctl                    link,
	input  wire logic                  req_valid_in,
	input  wire logic                  req_write_in,
	input  wire logic [bsp_pkg::ADDR_W-1:0]  req_addr_in,
	input  wire logic [bsp_pkg::WORD_W-1:0]  req_wdata_in,
	input  wire logic [bsp_pkg::WMASK_W-1:0] req_wmask_n_in,
	input  wire logic                  term_en_in,
	input  wire logic                  dll_off_n_in,
	output logic                       req_ready_out,
	output logic [bsp_pkg::WORD_W-1:0] rd_data_out,
	output logic                       rd_valid_out
);
	import bsp_pkg::*;

	// ==========================================================
	// Phase and command issue
	logic                phase_reg;
	logic                ready_reg;
	logic [ADDR_W-1:0]   adr_reg;
	logic                ld_n_reg;
	logic                rw_reg;
	logic                odt_reg;
	logic                dll_reg;
	bsp_cmd_t            cp [CTL_PIPE];
	logic [WORD_W-1:0]   wd [WR_BEAT2];
	logic [WMASK_W-1:0]  wm [WR_BEAT2];
	wire                 take = req_valid_in && ready_reg;
	wire bsp_cmd_t       cnew = !take ? CMD_NOP : (req_write_in ? CMD_WR : CMD_RD);
	// Holds off new requests for two primary cycles after a read, so no write beat lands in its later data slots.
	wire                 rd_hold = (cp[0] == CMD_RD) ||
		(cp[RD_LAT-WR_BEAT1] == CMD_RD);

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			phase_reg <= 1'b0;
			ready_reg <= 1'b0;
			adr_reg   <= '0;
			ld_n_reg  <= 1'b1;
			rw_reg    <= 1'b1;
			odt_reg   <= 1'b0;
			dll_reg   <= 1'b0;
		end else begin
			phase_reg <= !phase_reg;
			ready_reg <= phase_reg && !rd_hold;
			adr_reg   <= req_addr_in;
			ld_n_reg  <= !take;
			rw_reg    <= !(take && req_write_in);
			odt_reg   <= term_en_in;
			dll_reg   <= dll_off_n_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int i = 0; i < CTL_PIPE; i++) begin
				cp[i] <= CMD_NOP;
			end
			for (int i = 0; i < WR_BEAT2; i++) begin
				wd[i] <= '0;
				wm[i] <= '1;
			end
		end else begin
			cp[0] <= cnew;
			wd[0] <= req_wdata_in;
			wm[0] <= req_wmask_n_in;
			for (int i = 1; i < CTL_PIPE; i++) begin
				cp[i] <= cp[i-1];
			end
			for (int i = 1; i < WR_BEAT2; i++) begin
				wd[i] <= wd[i-1];
				wm[i] <= wm[i-1];
			end
		end
	end

	// ==========================================================
	// Data beats and bus turnaround
	wire                 b1 = (cp[WR_BEAT1-1] == CMD_WR);
	wire                 b2 = (cp[WR_BEAT2-1] == CMD_WR);
	wire                 rd_win = (cp[RD_LAT] == CMD_RD) || (cp[RD_LAT+1] == CMD_RD);
	wire                 cap1 = (cp[RD_LAT+1] == CMD_RD);
	wire                 cap2 = (cp[RD_LAT+2] == CMD_RD);
	wire [DQ_W-1:0]      d_next = b1 ? wd[WR_BEAT1-1][DQ_W-1:0] :
		b2 ? wd[WR_BEAT2-1][WORD_W-1:DQ_W] : '0;
	wire [LANES-1:0]     m_next = b1 ? wm[WR_BEAT1-1][LANES-1:0] :
		b2 ? wm[WR_BEAT2-1][WMASK_W-1:LANES] : '1;

	logic [DQ_W-1:0]     d_reg;
	logic [LANES-1:0]    m_reg;
	logic                oe_n_reg;
	logic [WORD_W-1:0]   rdat_reg;
	logic                rval_reg;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			d_reg    <= '0;
			m_reg    <= '1;
			oe_n_reg <= 1'b0;
			rdat_reg <= '0;
			rval_reg <= 1'b0;
		end else begin
			d_reg    <= d_next;
			m_reg    <= m_next;
			oe_n_reg <= rd_win;
			if (cap1) begin
				rdat_reg[DQ_W-1:0] <= link.dev_dq;
			end
			if (cap2) begin
				rdat_reg[WORD_W-1:DQ_W] <= link.dev_dq;
			end
			rval_reg <= cap2;
		end
	end

	assign link.k_phase             = phase_reg;
	assign link.sync_address_inputs = adr_reg;
	assign link.load_strobe_n       = ld_n_reg;
	assign link.rw_select           = rw_reg;
	assign link.byte_write_masks_n  = m_reg;
	assign link.ctl_dq              = d_reg;
	assign link.ctl_dq_oe_n         = oe_n_reg;
	assign link.termination_enable  = odt_reg;
	assign link.dll_off_n           = dll_reg;
	assign req_ready_out            = ready_reg;
	assign rd_data_out              = rdat_reg;
	assign rd_valid_out             = rval_reg;
endmodule : bsp_sram_ctl

// File: rtl/bsp_sram_dev.sv
// SRAM device end: command pipeline, late-write capture, masked storage, read return.
// Assumes the controller end shares clk_sys_in; strap pins arrive asynchronously.
`timescale 1ns/100ps
module bsp_sram_dev (
	input  wire logic clk_sys_in,
	input  wire logic arst_n_in,
	bsp_link_if.dev   link,
	output logic      dll_enabled_out,
	output logic      term_active_out
);
	import bsp_pkg::*;

	// ==========================================================
	// Strap synchronisers
	logic [2:0] odt_sync_reg;
	logic [2:0] dll_sync_reg;
	logic       odt_reg;
	logic       dll_reg;
	wire        odt_next = (odt_sync_reg[1] == odt_sync_reg[2]) ? odt_sync_reg[2] : odt_reg;
	wire        dll_next = (dll_sync_reg[1] == dll_sync_reg[2]) ? dll_sync_reg[2] : dll_reg;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			odt_sync_reg <= 3'h0;
			dll_sync_reg <= 3'h0;
			odt_reg      <= 1'b0;
			dll_reg      <= 1'b0;
		end else begin
			odt_sync_reg <= {odt_sync_reg[1:0], link.termination_enable};
			dll_sync_reg <= {dll_sync_reg[1:0], link.dll_off_n};
			odt_reg      <= odt_next;
			dll_reg      <= dll_next;
		end
	end

	// ==========================================================
	// Command pipeline
	bsp_cmd_t          cmd_pipe [DEV_PIPE];
	logic [ADDR_W-1:0] adr_pipe [DEV_PIPE];
	wire               cmd_take = link.k_phase && !link.load_strobe_n;
	wire bsp_cmd_t     cmd_new  = !cmd_take ? CMD_NOP :
		(link.rw_select ? CMD_RD : CMD_WR);

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int i = 0; i < DEV_PIPE; i++) begin
				cmd_pipe[i] <= CMD_NOP;
				adr_pipe[i] <= '0;
			end
		end else begin
			cmd_pipe[0] <= cmd_new;
			adr_pipe[0] <= link.sync_address_inputs;
			for (int i = 1; i < DEV_PIPE; i++) begin
				cmd_pipe[i] <= cmd_pipe[i-1];
				adr_pipe[i] <= adr_pipe[i-1];
			end
		end
	end

	// ==========================================================
	// Storage and write path
	logic [WORD_W-1:0]  mem_reg [DEPTH];
	logic [DQ_W-1:0]    wbeat_reg;
	logic [LANES-1:0]   wmask_reg;
	wire                wr_b1 = (cmd_pipe[WR_BEAT1-1] == CMD_WR);
	wire                wr_b2 = (cmd_pipe[WR_BEAT2-1] == CMD_WR);
	wire [ADDR_W-1:0]   wr_adr = adr_pipe[WR_BEAT2-1];

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wbeat_reg <= '0;
			wmask_reg <= '1;
		end else if (wr_b1) begin
			wbeat_reg <= link.ctl_dq;
			wmask_reg <= link.byte_write_masks_n;
		end
	end

	wire [WORD_W-1:0]   wr_word;

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			// Each lane of LANE_W lines has its own mask in each beat.
			assign wr_word[g*LANE_W +: LANE_W] = wmask_reg[g] ?
				mem_reg[wr_adr][g*LANE_W +: LANE_W] :
				wbeat_reg[g*LANE_W +: LANE_W];
			assign wr_word[DQ_W + g*LANE_W +: LANE_W] = link.byte_write_masks_n[g] ?
				mem_reg[wr_adr][DQ_W + g*LANE_W +: LANE_W] :
				link.ctl_dq[g*LANE_W +: LANE_W];
		end
	endgenerate

	// One process owns the storage; masked lanes write back their old contents.
	always_ff @(posedge clk_sys_in) begin
		if (wr_b2) begin
			mem_reg[wr_adr] <= wr_word;
		end
	end

	// ==========================================================
	// Read return, driver and termination control
	wire        rd_b1  = (cmd_pipe[RD_LAT-1] == CMD_RD);
	wire        rd_b2  = (cmd_pipe[RD_LAT] == CMD_RD);
	wire        rd_any = rd_b1 || rd_b2;
	wire        rd_near = (cmd_pipe[RD_LAT-1-TERM_LEAD] == CMD_RD) || rd_any ||
		(cmd_pipe[RD_LAT+TERM_LEAD] == CMD_RD);
	wire [DQ_W-1:0] q_next = rd_b1 ? mem_reg[adr_pipe[RD_LAT-1]][DQ_W-1:0] :
		rd_b2 ? mem_reg[adr_pipe[RD_LAT]][WORD_W-1:DQ_W] : '0;

	logic [DQ_W-1:0] q_reg;
	logic            q_oe_n_reg;
	logic            echo_reg;
	logic            term_reg;
	logic            rv_reg;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q_reg      <= '0;
			q_oe_n_reg <= 1'b1;
			echo_reg   <= 1'b0;
			term_reg   <= 1'b0;
			rv_reg     <= 1'b0;
		end else begin
			q_reg      <= q_next;
			q_oe_n_reg <= !rd_any;
			echo_reg   <= link.k_phase;
			term_reg   <= odt_reg && !rd_near;
			rv_reg     <= rd_any;
		end
	end

	assign link.dev_dq          = q_reg;
	assign link.dev_dq_oe_n     = q_oe_n_reg;
	assign link.read_valid_out  = rv_reg;
	assign link.echo_timing_out = echo_reg;
	assign dll_enabled_out      = dll_reg;
	assign term_active_out      = term_reg;
endmodule : bsp_sram_dev

// File: sim/bsp_link_sva.sv
// Checker for the link between the controller end and the device end.
// Assumes it sits beside the link interface and shares its clock and reset.
`timescale 1ns/100ps
module bsp_link_sva (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic k_phase,
	input wire logic load_strobe_n,
	input wire logic rw_select,
	input wire logic ctl_dq_oe_n,
	input wire logic dev_dq_oe_n,
	input wire logic echo_timing_out,
	input wire logic read_valid_out
);
	// ==========================================
	// Link timing checks.
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);
	chk_cmd_primary_only: assert property (!load_strobe_n |-> k_phase)
		else $error("command outside primary edge");
	chk_read_two_beats: assert property (k_phase && !load_strobe_n && rw_select
		|-> ##5 !dev_dq_oe_n ##1 !dev_dq_oe_n) else $error("read beats missing");
	chk_idle_release: assert property (k_phase && (load_strobe_n || !rw_select)
		|-> ##6 dev_dq_oe_n) else $error("drivers not released");
	chk_write_beats_driven: assert property (k_phase && !load_strobe_n && !rw_select
		|-> ##2 !ctl_dq_oe_n ##1 !ctl_dq_oe_n) else $error("write beats not driven");
	chk_no_bus_fight: assert property (!(!ctl_dq_oe_n && !dev_dq_oe_n))
		else $error("both ends drive data");
	chk_valid_follows_oe: assert property (read_valid_out == !dev_dq_oe_n)
		else $error("read valid off drive window");
	chk_valid_pairs: assert property ($rose(read_valid_out) |-> ##1 read_valid_out)
		else $error("read valid not two beats");
	chk_echo_delay: assert property (echo_timing_out == $past(k_phase))
		else $error("echo clock not delayed phase");
endmodule : bsp_link_sva

// File: sim/testbench.sv
// Self-checking bench joining the controller end and the device end.
// Assumes the package and interface are compiled first.
`timescale 1ns/100ps
module testbench;
	import bsp_pkg::*;
	logic               clk_sys = 1'b0;
	logic               arst_n = 1'b0;
	logic               req_valid = 1'b0;
	logic               req_write = 1'b0;
	logic [ADDR_W-1:0]  req_addr = '0;
	logic [WORD_W-1:0]  req_wdata = '0;
	logic [WMASK_W-1:0] req_wmask_n = '1;
	logic               term_en = 1'b1;
	logic               dll_off_n = 1'b1;
	logic               req_ready;
	logic [WORD_W-1:0]  rd_data;
	logic               rd_valid;
	logic               dll_en;
	logic               term_act;
	logic [WORD_W-1:0]  rq[$];
	int                 failures = 0;
	int                 num_checks = 0;
	bsp_link_if link ();
	bsp_sram_ctl u_bsp_sram_ctl (.clk_sys_in(clk_sys), .arst_n_in(arst_n), .link(link),
		.req_valid_in(req_valid), .req_write_in(req_write), .req_addr_in(req_addr),
		.req_wdata_in(req_wdata), .req_wmask_n_in(req_wmask_n), .term_en_in(term_en),
		.dll_off_n_in(dll_off_n), .req_ready_out(req_ready), .rd_data_out(rd_data),
		.rd_valid_out(rd_valid));
	bsp_sram_dev u_bsp_sram_dev (.clk_sys_in(clk_sys), .arst_n_in(arst_n), .link(link),
		.dll_enabled_out(dll_en), .term_active_out(term_act));
	bsp_link_sva u_bsp_link_sva (.clk_sys_in(clk_sys), .arst_n_in(arst_n),
		.k_phase(link.k_phase), .load_strobe_n(link.load_strobe_n),
		.rw_select(link.rw_select), .ctl_dq_oe_n(link.ctl_dq_oe_n),
		.dev_dq_oe_n(link.dev_dq_oe_n), .echo_timing_out(link.echo_timing_out),
		.read_valid_out(link.read_valid_out));
	// ==========================================
	// Clock, read capture and helpers.
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (rd_valid === 1'b1) rq.push_back(rd_data);
	task check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	task req(input logic wr, input int a, input logic [WORD_W-1:0] d, input int m);
		int n;
		n = 0;
		req_valid <= 1'b1;
		req_write <= wr;
		req_addr <= a[ADDR_W-1:0];
		req_wdata <= d;
		req_wmask_n <= m[WMASK_W-1:0];
		do begin
			@(posedge clk_sys);
			n++;
		end while (req_ready !== 1'b1 && n < 20);
		if (n >= 20) check(WORD_W'(0), WORD_W'(1), "request not taken");
	endtask : req
	task idle(input int c);
		req_valid <= 1'b0;
		repeat (c) @(posedge clk_sys);
	endtask : idle
	task pop_check(input logic [WORD_W-1:0] exp, input string what);
		int n;
		n = 0;
		while (rq.size() == 0 && n < 30) begin
			@(posedge clk_sys);
			n++;
		end
		if (rq.size() == 0) check(WORD_W'(0), WORD_W'(1), "read missing");
		else check(rq.pop_front(), exp, what);
	endtask : pop_check
	function automatic logic [WORD_W-1:0] merge(logic [WORD_W-1:0] o, logic [WORD_W-1:0] w,
		int m);
		logic [WORD_W-1:0] r;
		for (int i = 0; i < WMASK_W; i++) r[i*LANE_W +: LANE_W] = m[i] ? o[i*LANE_W +: LANE_W]
			: w[i*LANE_W +: LANE_W];
		return r;
	endfunction : merge
	// ==========================================
	// Scenarios.
	task t_mask_mix;
		for (int m = 0; m < 16; m++) req(1'b1, m, 36'hF0F0F0F00 ^ WORD_W'(m), 0);
		for (int m = 0; m < 16; m++) req(1'b1, m, 36'h123456789 + WORD_W'(m), m);
		for (int m = 0; m < 16; m++) req(1'b0, m, '0, 15);
		idle(20);
		for (int m = 0; m < 16; m++) pop_check(merge(36'hF0F0F0F00 ^ WORD_W'(m),
			36'h123456789 + WORD_W'(m), m), "masked word");
		$display("test mask_mix done");
	endtask : t_mask_mix
	task t_turnaround;
		req(1'b1, 2, 36'hABCDE1234, 0);
		req(1'b0, 2, '0, 15);
		req(1'b1, 2, 36'h0FEDCBA98, 3);
		req(1'b0, 2, '0, 15);
		idle(20);
		pop_check(36'hABCDE1234, "read after write");
		pop_check(merge(36'hABCDE1234, 36'h0FEDCBA98, 3), "masked rewrite");
		$display("test turnaround done");
	endtask : t_turnaround
	task t_straps;
		int lows;
		lows = 0;
		check(WORD_W'(dll_en), WORD_W'(1), "dll on");
		check(WORD_W'(term_act), WORD_W'(1), "term on");
		req(1'b0, 2, '0, 15);
		req_valid <= 1'b0;
		repeat (12) @(posedge clk_sys) lows += (term_act === 1'b0);
		check(WORD_W'(lows), WORD_W'(2 + 2 * TERM_LEAD), "term off around read");
		rq.delete();
		dll_off_n <= 1'b0;
		term_en <= 1'b0;
		idle(8);
		check(WORD_W'(dll_en), WORD_W'(0), "dll off");
		check(WORD_W'(term_act), WORD_W'(0), "term off");
		dll_off_n <= 1'b1;
		term_en <= 1'b1;
		idle(8);
		$display("test straps done");
	endtask : t_straps
	task t_reset_mid;
		arst_n <= 1'b0;
		idle(3);
		check(WORD_W'(link.dev_dq_oe_n), WORD_W'(1), "drivers off in reset");
		check(WORD_W'(req_ready), WORD_W'(0), "not ready in reset");
		arst_n <= 1'b1;
		idle(6);
		req(1'b0, 2, '0, 15);
		idle(20);
		pop_check(merge(36'hABCDE1234, 36'h0FEDCBA98, 3), "kept over reset");
		$display("test reset_mid done");
	endtask : t_reset_mid
	task summarize;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	initial begin
		#(4000 * 100);
		failures++;
		summarize();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		idle(2);
		t_mask_mix();
		t_turnaround();
		t_straps();
		t_reset_mid();
		summarize();
	end
endmodule : testbench
